// [lpm_regs.vh]
/*
 * register map and field constants for the low power mode controller.
 * assumes an ahb-lite bus with 32-bit data and word-aligned registers.
 */
`ifndef LPM_REGS_VH
`define LPM_REGS_VH

// byte offsets
`define LPM_PWR_CTRL_OFS 8'h00
`define LPM_PLL_CTRL_OFS 8'h04
`define LPM_STATUS_OFS 8'h08
`define LPM_WAKE_SRC_OFS 8'h0c
`define LPM_ADDR_W 8

// power control register fields
`define LPM_PC_IDLE_BIT 0
`define LPM_PC_PD_BIT 1
`define LPM_PC_EXT0_WAKE_BIT 3
`define LPM_PC_SER_WAKE_BIT 4
`define LPM_PC_MASK 32'h0000001b
`define LPM_PC_RESET 32'h00000000

// pll control register fields
`define LPM_PLL_OSC_OFF_BIT 3
`define LPM_PLL_MASK 32'h00000008
`define LPM_PLL_RESET 32'h00000000

// mode encodings in the status register
`define LPM_MODE_W 3
`define LPM_ST_NORMAL 3'h1
`define LPM_ST_IDLE 3'h2
`define LPM_ST_PDOWN 3'h4

// ahb-lite encodings
`define LPM_HTRANS_NONSEQ 2'h2
`define LPM_HTRANS_SEQ 2'h3
`define LPM_HSIZE_WORD 3'h2

`endif

// [lpm_ctrl.v]
/*
 * low power mode controller: idle and power-down sequencing, wake gating,
 * and the clock, strobe and dac-output gates that each mode needs.
 * assumes ahb-lite single word transfers on hclk, and wake/reset pins that
 * arrive asynchronously and are synchronised here.
 */
// Our own choices: the address map and the AHB-Lite register port.
// Behaviour
// (R1) reset pin high holds device in reset
// (R2) control bit0 idle, bit1 power-down
// (R3) idle: oscillator runs, core clock stops
// (R4) idle keeps state; strobes driven high
// (R5) any enabled interrupt or reset ends idle
// (R6) power-down stops pll and core clock
// (R7) oscillator off in power-down if selected
// (R8) only interval counter may run in power-down
// (R9) power-down: pins held, dac hi-z, strobes low
// (R10) reset in power-down restores defaults
// (R11) interval counter interrupt ends power-down
// (R12) serial interrupt wakes if enable set
// (R13) ext_irq0 wakes if its enable set
// (R14) both bits set means power-down; auto clear
`timescale 1ns/100ps
`include "lpm_regs.vh"

module lpm_ctrl (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire reset_pin,
	input wire irq_enabled_pending,
	input wire interval_counter_irq,
	input wire serial_irq,
	input wire ext_irq0,
	input wire interval_counter_en,
	output reg core_clk_en,
	output reg pll_en,
	output reg osc_en,
	output reg periph_clk_en,
	output reg interval_counter_clk_en,
	output reg strobe_force_en,
	output reg strobe_force_val,
	output reg port_hold,
	output reg dac_out_hiz,
	output reg cpu_reset,
	output reg wake_service_req
);

	// mode states, one-hot
	localparam [`LPM_MODE_W-1:0] ST_NORMAL = `LPM_ST_NORMAL;
	localparam [`LPM_MODE_W-1:0] ST_IDLE = `LPM_ST_IDLE;
	localparam [`LPM_MODE_W-1:0] ST_PDOWN = `LPM_ST_PDOWN;

	// two-flop synchronisers for the asynchronous pins
	reg [4:0] sync1_ff;
	reg [4:0] sync2_ff;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
		end else begin
			sync1_ff <= {reset_pin, irq_enabled_pending, interval_counter_irq, serial_irq, ext_irq0};
			sync2_ff <= sync1_ff;
		end
	end
	wire rst_s = sync2_ff[4];
	wire irq_s = sync2_ff[3];
	wire tic_s = sync2_ff[2];
	wire ser_s = sync2_ff[1];
	wire ext0_s = sync2_ff[0];

	// bus address phase capture
	reg wr_pend_ff;
	reg [`LPM_ADDR_W-1:0] addr_ff;
	wire take = hsel && hready && (htrans == `LPM_HTRANS_NONSEQ || htrans == `LPM_HTRANS_SEQ);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			addr_ff <= {`LPM_ADDR_W{1'b0}};
		end else begin
			wr_pend_ff <= take && hwrite;
			if (take)
				addr_ff <= haddr[`LPM_ADDR_W-1:0];
		end
	end

	// registers and mode state
	reg [31:0] pwr_ctrl_ff;
	reg [31:0] pll_ctrl_ff;
	reg [`LPM_MODE_W-1:0] mode_ff;
	reg [2:0] wake_src_ff;
	reg [31:0] nxt_pwr_ctrl;
	reg [31:0] nxt_pll_ctrl;
	reg [`LPM_MODE_W-1:0] nxt_mode;
	reg [2:0] nxt_wake_src;
	reg nxt_wake_req;

	wire ser_wake = ser_s && pwr_ctrl_ff[`LPM_PC_SER_WAKE_BIT]; // [R12]
	wire ext0_wake = ext0_s && pwr_ctrl_ff[`LPM_PC_EXT0_WAKE_BIT]; // [R13]
	wire pd_wake = tic_s || ser_wake || ext0_wake; // [R11]

	// mode sequencing and register writes
	always @* begin
		nxt_pwr_ctrl = pwr_ctrl_ff;
		nxt_pll_ctrl = pll_ctrl_ff;
		nxt_mode = mode_ff;
		nxt_wake_src = wake_src_ff;
		nxt_wake_req = 1'b0;
		if (wr_pend_ff && addr_ff == `LPM_PWR_CTRL_OFS)
			nxt_pwr_ctrl = hwdata & `LPM_PC_MASK;
		if (wr_pend_ff && addr_ff == `LPM_PLL_CTRL_OFS)
			nxt_pll_ctrl = hwdata & `LPM_PLL_MASK;
		case (mode_ff)
			ST_NORMAL: begin
				if (nxt_pwr_ctrl[`LPM_PC_PD_BIT])
					nxt_mode = ST_PDOWN; // [R2] [R14]
				else if (nxt_pwr_ctrl[`LPM_PC_IDLE_BIT])
					nxt_mode = ST_IDLE; // [R2]
			end
			ST_IDLE: begin
				if (irq_s) begin
					nxt_mode = ST_NORMAL; // [R5]
					nxt_pwr_ctrl[`LPM_PC_IDLE_BIT] = 1'b0; // [R14]
					nxt_pwr_ctrl[`LPM_PC_PD_BIT] = 1'b0;
					nxt_wake_req = 1'b1;
				end
			end
			ST_PDOWN: begin
				if (pd_wake) begin
					nxt_mode = ST_NORMAL; // [R11] [R12] [R13]
					nxt_pwr_ctrl[`LPM_PC_IDLE_BIT] = 1'b0; // [R14]
					nxt_pwr_ctrl[`LPM_PC_PD_BIT] = 1'b0;
					nxt_wake_src = {ser_wake, ext0_wake, tic_s};
					nxt_wake_req = 1'b1;
				end
			end
			default: begin
				nxt_mode = ST_NORMAL;
			end
		endcase
	end

	// state flops; the reset pin restores every default
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_ctrl_ff <= `LPM_PC_RESET;
			pll_ctrl_ff <= `LPM_PLL_RESET;
			mode_ff <= ST_NORMAL;
			wake_src_ff <= 3'h0;
			wake_service_req <= 1'b0;
			cpu_reset <= 1'b1;
		end else if (rst_s) begin
			pwr_ctrl_ff <= `LPM_PC_RESET; // [R10] [R5]
			pll_ctrl_ff <= `LPM_PLL_RESET;
			mode_ff <= ST_NORMAL;
			wake_src_ff <= 3'h0;
			wake_service_req <= 1'b0;
			cpu_reset <= 1'b1; // [R1]
		end else begin
			pwr_ctrl_ff <= nxt_pwr_ctrl;
			pll_ctrl_ff <= nxt_pll_ctrl;
			mode_ff <= nxt_mode;
			wake_src_ff <= nxt_wake_src;
			wake_service_req <= nxt_wake_req;
			cpu_reset <= 1'b0; // [R1]
		end
	end

	// clock, strobe and pin gating outputs, registered from next mode
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_clk_en <= 1'b1;
			pll_en <= 1'b1;
			osc_en <= 1'b1;
			periph_clk_en <= 1'b1;
			interval_counter_clk_en <= 1'b1;
			strobe_force_en <= 1'b0;
			strobe_force_val <= 1'b0;
			port_hold <= 1'b0;
			dac_out_hiz <= 1'b0;
		end else begin
			// idle keeps registers by gating only the core clock
			core_clk_en <= (nxt_mode == ST_NORMAL) || rst_s; // [R3] [R6] [R4]
			pll_en <= (nxt_mode != ST_PDOWN) || rst_s; // [R6] [R3]
			osc_en <= (nxt_mode != ST_PDOWN) || rst_s ||
				!pll_ctrl_ff[`LPM_PLL_OSC_OFF_BIT]; // [R7]
			periph_clk_en <= (nxt_mode != ST_PDOWN) || rst_s; // [R8] [R3]
			interval_counter_clk_en <= (nxt_mode != ST_PDOWN) || rst_s ||
				interval_counter_en; // [R8]
			strobe_force_en <= (nxt_mode != ST_NORMAL) && !rst_s; // [R4] [R9]
			strobe_force_val <= (nxt_mode == ST_IDLE); // [R4] [R9]
			port_hold <= (nxt_mode != ST_NORMAL) && !rst_s; // [R4] [R9]
			dac_out_hiz <= (nxt_mode == ST_PDOWN) && !rst_s; // [R9]
		end
	end

	// ahb-lite data phase: zero wait states, always okay
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (take && !hwrite) begin
				case (haddr[`LPM_ADDR_W-1:0])
					`LPM_PWR_CTRL_OFS: hrdata <= pwr_ctrl_ff;
					`LPM_PLL_CTRL_OFS: hrdata <= pll_ctrl_ff;
					`LPM_STATUS_OFS: hrdata <= {29'h0, mode_ff};
					`LPM_WAKE_SRC_OFS: hrdata <= {29'h0, wake_src_ff};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// [lpm_ctrl_checker.sv]
/* mode output assertions for lpm_ctrl; bound by name to its ports */
`timescale 1ns/100ps
module lpm_ctrl_checker (
	input wire hclk,
	input wire hresetn,
	input wire reset_pin,
	input wire interval_counter_en,
	input wire core_clk_en,
	input wire pll_en,
	input wire osc_en,
	input wire periph_clk_en,
	input wire interval_counter_clk_en,
	input wire strobe_force_en,
	input wire strobe_force_val,
	input wire port_hold,
	input wire dac_out_hiz,
	input wire cpu_reset,
	input wire wake_service_req
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// idle and power-down output sets
	chk_idle_clocks: assert property (!core_clk_en && pll_en |-> osc_en && periph_clk_en)
		else $error("idle clocks wrong");
	chk_idle_pins: assert property (!core_clk_en && pll_en |-> strobe_force_en && strobe_force_val && port_hold && !dac_out_hiz)
		else $error("idle pins wrong");
	chk_pd_pins: assert property (!pll_en |-> !core_clk_en && !periph_clk_en && strobe_force_en && !strobe_force_val && port_hold && dac_out_hiz)
		else $error("power-down pins wrong");
	chk_tic_gate: assert property ($past(!pll_en) && !pll_en |-> interval_counter_clk_en == $past(interval_counter_en))
		else $error("interval counter gate wrong");
	chk_oscillator_off_in_sleep: assert property (!osc_en |-> !pll_en)
		else $error("oscillator off outside power-down");
	chk_entry_strobe: assert property ($fell(core_clk_en) |-> strobe_force_en && port_hold)
		else $error("strobes not forced");
	// wake pulse is single and clocks follow it
	chk_wake_pulse: assert property (wake_service_req |=> !wake_service_req && core_clk_en && pll_en)
		else $error("wake exit wrong");
	chk_pin_reset: assert property (reset_pin [*5] |-> cpu_reset && core_clk_en && pll_en && !dac_out_hiz)
		else $error("reset pin ignored");
endmodule

// [lpm_ctrl_src.sv]
/* reset circuit and wake sources; the bench drives them through tasks */
`timescale 1ns/100ps
module lpm_ctrl_src (
	input wire hclk,
	output reg reset_pin,
	output reg irq_enabled_pending,
	output reg interval_counter_irq,
	output reg serial_irq,
	output reg ext_irq0
);
	// power-on: held high, then driven low
	initial begin
		reset_pin = 1'b1;
		{ext_irq0, serial_irq, interval_counter_irq, irq_enabled_pending} = 4'h0;
		repeat (4) @(posedge hclk);
		reset_pin <= 1'b0;
	end
	// wake levels set after an edge
	task lv(input [3:0] v);
		@(posedge hclk);
		{ext_irq0, serial_irq, interval_counter_irq, irq_enabled_pending} <= v;
	endtask
	// reset pulse of n cycles
	task rst(input integer n);
		@(posedge hclk);
		reset_pin <= 1'b1;
		repeat (n) @(posedge hclk);
		reset_pin <= 1'b0;
	endtask
endmodule

// [lpm_ctrl_tb.sv]
/* bench for lpm_ctrl; sources from lpm_ctrl_src, ahb-lite master tasks */
`timescale 1ns/100ps
`include "lpm_regs.vh"
module lpm_ctrl_tb;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg hwrite = 1'b0;
	reg [1:0] htrans = 2'h0;
	reg [2:0] hsize = `LPM_HSIZE_WORD;
	reg [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	reg interval_counter_en = 1'b1;
	integer error_cnt = 0, check_count = 0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, reset_pin, irq_enabled_pending, interval_counter_irq, serial_irq, ext_irq0;
	wire core_clk_en, pll_en, osc_en, periph_clk_en, interval_counter_clk_en, strobe_force_en;
	wire strobe_force_val, port_hold, dac_out_hiz, cpu_reset, wake_service_req;
	wire hready = hreadyout;
	always #5 hclk = ~hclk;
	lpm_ctrl i_dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.reset_pin(reset_pin),
		.irq_enabled_pending(irq_enabled_pending),
		.interval_counter_irq(interval_counter_irq),
		.serial_irq(serial_irq),
		.ext_irq0(ext_irq0),
		.interval_counter_en(interval_counter_en),
		.core_clk_en(core_clk_en),
		.pll_en(pll_en),
		.osc_en(osc_en),
		.periph_clk_en(periph_clk_en),
		.interval_counter_clk_en(interval_counter_clk_en),
		.strobe_force_en(strobe_force_en),
		.strobe_force_val(strobe_force_val),
		.port_hold(port_hold),
		.dac_out_hiz(dac_out_hiz),
		.cpu_reset(cpu_reset),
		.wake_service_req(wake_service_req)
	);
	lpm_ctrl_src u_src (
		.hclk(hclk),
		.reset_pin(reset_pin),
		.irq_enabled_pending(irq_enabled_pending),
		.interval_counter_irq(interval_counter_irq),
		.serial_irq(serial_irq),
		.ext_irq0(ext_irq0)
	);
	task test_done;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task ck(input [31:0] s, e, input [8*8:1] nm);
		check_count = check_count + 1;
		if (s !== e) begin
			error_cnt = error_cnt + 1;
			$display("BAD %0s exp %h got %h", nm, e, s);
		end
	endtask
	// bounded wait for hready
	task wt;
		integer n;
		n = 0;
		do begin
			@(posedge hclk);
			n = n + 1;
			if (n > 50) begin
				error_cnt = error_cnt + 1;
				test_done;
			end
		end while (hreadyout !== 1'b1);
	endtask
	task bus(input [7:0] a, input w, input [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= `LPM_HTRANS_NONSEQ;
		wt;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt;
		q = hrdata;
	endtask
	// watch a window for the wake pulse, then read the mode
	task ww(input e, input [31:0] st);
		integer n;
		reg g;
		g = 1'b0;
		for (n = 0; n < 20; n = n + 1) begin
			@(posedge hclk);
			#1;
			if (wake_service_req === 1'b1)
				g = 1'b1;
		end
		ck(g, e, "wake");
		bus(`LPM_STATUS_OFS, 1'b0, 32'h0);
		ck(q, st, "mode");
	endtask
	task sc_idle;
		bus(`LPM_PWR_CTRL_OFS, 1'b1, 32'h1);
		repeat (2) @(posedge hclk);
		#1;
		ck(core_clk_en, 1'b0, "core");
		ck(pll_en, 1'b1, "pll");
		ck(periph_clk_en, 1'b1, "periph");
		ck(strobe_force_val, 1'b1, "strobe");
		ck(port_hold, 1'b1, "hold");
		ck(dac_out_hiz, 1'b0, "dac");
		u_src.lv(4'h1);
		ww(1'b1, 32'h1);
		u_src.lv(4'h0);
	endtask
	// power-down with both bits, source v; tic ends it if v is gated
	task sc_pd(input [31:0] osc, en, input [3:0] v, input e);
		interval_counter_en <= !osc[3];
		bus(`LPM_PLL_CTRL_OFS, 1'b1, osc);
		bus(`LPM_PWR_CTRL_OFS, 1'b1, en | 32'h3);
		repeat (2) @(posedge hclk);
		#1;
		ck(osc_en, !osc[3], "osc");
		ck(pll_en, 1'b0, "pll");
		ck(periph_clk_en, 1'b0, "periph");
		ck(interval_counter_clk_en, !osc[3], "ticclk");
		ck(dac_out_hiz, 1'b1, "dac");
		ck(strobe_force_val, 1'b0, "strobe");
		u_src.lv(v);
		ww(e, e ? 32'h1 : 32'h4);
		u_src.lv(4'h2);
		ww(!e, 32'h1);
		u_src.lv(4'h0);
		bus(`LPM_WAKE_SRC_OFS, 1'b0, 32'h0);
		ck(q, !e ? 32'h1 : v == 4'h2 ? 32'h1 : v == 4'h4 ? 32'h4 : 32'h2, "wakesrc");
		bus(`LPM_PWR_CTRL_OFS, 1'b0, 32'h0);
		ck(q, en, "ctrl");
	endtask
	task sc_rst;
		bus(`LPM_PWR_CTRL_OFS, 1'b1, 32'h12);
		u_src.rst(6);
		repeat (4) @(posedge hclk);
		bus(`LPM_PWR_CTRL_OFS, 1'b0, 32'h0);
		ck(q, 32'h0, "ctrl");
		ck(cpu_reset, 1'b0, "cpurst");
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		bus(8'h10, 1'b1, 32'hffffffff);
		bus(8'h10, 1'b0, 32'h0);
		ck(q, 32'h0, "unmap");
		ck(hresp, 1'b0, "hresp");
		sc_idle;
		sc_pd(32'h8, 32'h0, 4'h2, 1'b1);
		sc_pd(32'h0, 32'h0, 4'h4, 1'b0);
		sc_pd(32'h0, 32'h10, 4'h4, 1'b1);
		sc_pd(32'h0, 32'h0, 4'h8, 1'b0);
		sc_pd(32'h8, 32'h8, 4'h8, 1'b1);
		sc_pd(32'h0, 32'h0, 4'h1, 1'b0);
		sc_rst;
		test_done;
	end
endmodule
bind lpm_ctrl lpm_ctrl_checker u_chk (
	.hclk(hclk),
	.hresetn(hresetn),
	.reset_pin(reset_pin),
	.interval_counter_en(interval_counter_en),
	.core_clk_en(core_clk_en),
	.pll_en(pll_en),
	.osc_en(osc_en),
	.periph_clk_en(periph_clk_en),
	.interval_counter_clk_en(interval_counter_clk_en),
	.strobe_force_en(strobe_force_en),
	.strobe_force_val(strobe_force_val),
	.port_hold(port_hold),
	.dac_out_hiz(dac_out_hiz),
	.cpu_reset(cpu_reset),
	.wake_service_req(wake_service_req)
);
